/* design/ipv4_access_list_filter.sv */
// ipv4 access list classifier with entry table and sequential scan
`timescale 1ns/10ps
module ipv4_access_list_filter #(
  parameter int ENTRIES = acl_filter_pkg::MAX_ENTRIES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // entry write port
  input wire logic wr_en,
  input wire logic [7:0] wr_index,
  input wire acl_filter_pkg::acl_entry_t wr_entry,
  // deletion commands
  input wire logic del_entry,
  input wire logic [7:0] del_index,
  input wire logic del_list,
  input wire logic [7:0] del_list_id,
  // entry read back
  input wire logic [7:0] rd_index,
  output logic [47:0] rd_flag_text,
  output logic rd_valid,
  // packet request
  input wire logic pkt_valid,
  output logic pkt_ready,
  input wire acl_filter_pkg::pkt_hdr_t pkt_hdr,
  // verdict
  output logic verdict_valid,
  output logic verdict_permit
);

  ////////////////////////////////////////////////////////////////////////
  // entry compare, all enabled criteria; ports compared only when the entry names tcp or udp and proto_any is clear
  function automatic logic entry_hit(input acl_filter_pkg::acl_entry_t e,
                                     input acl_filter_pkg::pkt_hdr_t p);
    logic l4;
    logic ok;
    int i;
    l4 = (e.proto == acl_filter_pkg::PROTO_TCP) || (e.proto == acl_filter_pkg::PROTO_UDP);
    ok = e.valid && (e.list_id == p.port_list);
    ok = ok && (e.proto_any || e.proto == p.proto);
    ok = ok && (!l4 || e.proto_any || e.sport_any || e.sport == p.sport);
    ok = ok && (!l4 || e.proto_any || e.dport_any || e.dport == p.dport);
    if (e.flags_en)
    begin
      for (i = 0; i < acl_filter_pkg::FLAG_COUNT; i++)
      begin
        if (e.flags[2*i +: 2] == acl_filter_pkg::FLAG_ONE)
          ok = ok && p.flags[i];
        else if (e.flags[2*i +: 2] == acl_filter_pkg::FLAG_ZERO)
          ok = ok && !p.flags[i];
      end
    end
    ok = ok && (e.saddr_any || ((e.saddr ^ p.saddr) & e.smask) == 32'h0);
    ok = ok && (e.daddr_any || ((e.daddr ^ p.daddr) & e.dmask) == 32'h0);
    case (e.qos_sel)
      acl_filter_pkg::QOS_DSCP: ok = ok && (e.qos_val == p.dscp);
      acl_filter_pkg::QOS_PREC: ok = ok && (e.qos_val[2:0] == p.dscp[5:3]);
      default: ok = ok;
    endcase
    return ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // entry table
  acl_filter_pkg::acl_entry_t table_mem [ENTRIES];
  logic [ENTRIES-1:0] live;
  logic [ENTRIES-1:0] next_live;

  // valid bits: write loads wr_entry.valid, deletions clear; table holds at most ENTRIES
  always_comb
  begin
    next_live = live;
    for (int k = 0; k < ENTRIES; k++)
    begin
      if (del_list && table_mem[k].list_id == del_list_id)
        next_live[k] = 1'b0;
    end
    if (del_entry)
      next_live[del_index] = 1'b0;
    if (wr_en)
      next_live[wr_index] = wr_entry.valid;
  end

  // register table contents and valid bits
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      live <= '0;
    else
      live <= next_live;
    if (wr_en)
      table_mem[wr_index] <= wr_entry;
  end

  ////////////////////////////////////////////////////////////////////////
  // read back of the flag setting as text
  logic [47:0] next_flag_text;
  always_comb
  begin
    acl_filter_pkg::acl_entry_t re;
    re = table_mem[rd_index];
    next_flag_text = '0;
    for (int f = 0; f < acl_filter_pkg::FLAG_COUNT; f++)
    begin
      // flag 5 is urg, placed in the top byte
      case (re.flags[2*f +: 2])
        acl_filter_pkg::FLAG_ONE: next_flag_text[8*f +: 8] = acl_filter_pkg::SYM_ONE;
        acl_filter_pkg::FLAG_ZERO: next_flag_text[8*f +: 8] = acl_filter_pkg::SYM_ZERO;
        default: next_flag_text[8*f +: 8] = acl_filter_pkg::SYM_IGNORE;
      endcase
      if (!re.flags_en)
        next_flag_text[8*f +: 8] = acl_filter_pkg::SYM_IGNORE;
    end
  end

  // register read back
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rd_flag_text <= '0;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_flag_text <= next_flag_text;
      rd_valid <= live[rd_index];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // classification scan, one entry per cycle
  acl_filter_pkg::scan_state_t state;
  acl_filter_pkg::scan_state_t next_state;
  acl_filter_pkg::pkt_hdr_t hdr;
  acl_filter_pkg::pkt_hdr_t next_hdr;
  logic [8:0] idx;
  logic [8:0] next_idx;
  logic next_verdict_valid;
  logic next_verdict_permit;
  logic hit;
  logic scan_permit;

  assign pkt_ready = (state == acl_filter_pkg::ST_IDLE);
  always_comb
  begin
    acl_filter_pkg::acl_entry_t ce;
    ce = table_mem[idx[7:0]];
    ce.valid = live[idx[7:0]];
    hit = entry_hit(ce, hdr);
    scan_permit = ce.permit; // action of the slot under scan
  end

  // scan next state
  always_comb
  begin
    next_state = state;
    next_hdr = hdr;
    next_idx = idx;
    next_verdict_valid = 1'b0;
    next_verdict_permit = verdict_permit;
    case (state)
      acl_filter_pkg::ST_IDLE:
      begin
        if (pkt_valid)
        begin
          next_hdr = pkt_hdr;
          next_idx = '0;
          if (pkt_hdr.bound)
            next_state = acl_filter_pkg::ST_SCAN;
          else
          begin
            next_verdict_valid = 1'b1; // unbound ports pass untouched
            next_verdict_permit = 1'b1;
          end
        end
      end
      acl_filter_pkg::ST_SCAN:
      begin
        if (hit)
        begin
          next_verdict_valid = 1'b1;
          next_verdict_permit = table_mem[idx[7:0]].permit;
          next_state = acl_filter_pkg::ST_DONE;
        end
        else if (idx == 9'(ENTRIES - 1))
        begin
          next_verdict_valid = 1'b1;
          next_verdict_permit = acl_filter_pkg::DEFAULT_PERMIT;
          next_state = acl_filter_pkg::ST_DONE;
        end
        else
          next_idx = idx + 9'h001;
      end
      acl_filter_pkg::ST_DONE: next_state = acl_filter_pkg::ST_IDLE;
      default: next_state = acl_filter_pkg::ST_IDLE;
    endcase
  end

  // scan registers
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state <= acl_filter_pkg::ST_IDLE;
      hdr <= '0;
      idx <= '0;
      verdict_valid <= 1'b0;
      verdict_permit <= 1'b0;
    end
    else
    begin
      state <= next_state;
      hdr <= next_hdr;
      idx <= next_idx;
      verdict_valid <= next_verdict_valid;
      verdict_permit <= next_verdict_permit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_verdict_once: assert property (@(posedge mclk) disable iff (sys_rst)
    (state == acl_filter_pkg::ST_SCAN && $past(state) == acl_filter_pkg::ST_IDLE)
    |-> ##[1:300] verdict_valid)
    else $error("bound packet got no verdict");
  a_hit_action: assert property (@(posedge mclk) disable iff (sys_rst)
    (state == acl_filter_pkg::ST_SCAN && hit)
    |=> verdict_valid && verdict_permit == $past(scan_permit))
    else $error("verdict does not follow entry action");
  a_miss_default: assert property (@(posedge mclk) disable iff (sys_rst)
    (state == acl_filter_pkg::ST_SCAN && !hit && idx == 9'(ENTRIES - 1))
    |=> verdict_valid && verdict_permit == acl_filter_pkg::DEFAULT_PERMIT)
    else $error("unmatched packet not given default action");
  a_scan_order: assert property (@(posedge mclk) disable iff (sys_rst)
    (state == acl_filter_pkg::ST_SCAN && !hit && idx != 9'(ENTRIES - 1))
    |=> state == acl_filter_pkg::ST_SCAN && idx == $past(idx) + 9'h001)
    else $error("scan skipped an entry");
  a_entry_delete: assert property (@(posedge mclk) disable iff (sys_rst)
    (del_entry && !(wr_en && wr_index == del_index)) |=> !live[$past(del_index)])
    else $error("deleted entry still live");
  a_list_delete: assert property (@(posedge mclk) disable iff (sys_rst)
    (del_list && !wr_en && live[rd_index] && table_mem[rd_index].list_id == del_list_id)
    |=> !live[$past(rd_index)])
    else $error("entry of deleted list still live");
  a_ready_idle: assert property (@(posedge mclk) disable iff (sys_rst)
    (verdict_valid && !(pkt_valid && pkt_ready && pkt_hdr.bound)) |=> pkt_ready)
    else $error("not ready after verdict");
  a_unbound_pass: assert property (@(posedge mclk) disable iff (sys_rst)
    (pkt_valid && pkt_ready && !pkt_hdr.bound) |=> verdict_valid && verdict_permit)
    else $error("unbound packet not passed");

endmodule // ipv4_access_list_filter

/* design/acl_filter_pkg.sv */
// shared constants and carriers for the ip access list filter
package acl_filter_pkg;

  // table sizes
  localparam int MAX_LISTS = 256;
  localparam int MAX_ENTRIES = 256;
  localparam int LIST_W = 8;
  localparam int ENTRY_W = 8;

  // protocol numbers for the predefined list
  localparam logic [7:0] PROTO_TCP = 8'h06;
  localparam logic [7:0] PROTO_UDP = 8'h11;

  // flag setting codes, two bits per flag
  localparam logic [1:0] FLAG_ZERO = 2'h0;
  localparam logic [1:0] FLAG_ONE = 2'h1;
  localparam logic [1:0] FLAG_IGNORE = 2'h2;

  // flag bit positions in the six-bit packet flag field (urg ack psh rst syn fin)
  localparam int FLAG_COUNT = 6;

  // symbol codes for the readable flag string
  localparam logic [7:0] SYM_ONE = 8'h31;
  localparam logic [7:0] SYM_ZERO = 8'h30;
  localparam logic [7:0] SYM_IGNORE = 8'h78;

  // qos field widths: dscp six bits, precedence three bits
  localparam int DSCP_W = 6;
  localparam int PREC_W = 3;

  // qos selection
  localparam logic [1:0] QOS_NONE = 2'h0;
  localparam logic [1:0] QOS_DSCP = 2'h1;
  localparam logic [1:0] QOS_PREC = 2'h2;

  // default action when nothing matches
  localparam logic DEFAULT_PERMIT = 1'b0;

  // one classification entry
  typedef struct packed {
    logic valid;
    logic [7:0] list_id;
    logic proto_any;
    logic [7:0] proto;
    logic sport_any;
    logic [15:0] sport;
    logic dport_any;
    logic [15:0] dport;
    logic flags_en;
    logic [11:0] flags;
    logic saddr_any;
    logic [31:0] saddr;
    logic [31:0] smask;
    logic daddr_any;
    logic [31:0] daddr;
    logic [31:0] dmask;
    logic [1:0] qos_sel;
    logic [5:0] qos_val;
    logic permit;
  } acl_entry_t;

  // packet header summary from the parser
  typedef struct packed {
    logic [7:0] port_list;
    logic bound;
    logic [7:0] proto;
    logic [15:0] sport;
    logic [15:0] dport;
    logic [5:0] flags;
    logic [31:0] saddr;
    logic [31:0] daddr;
    logic [5:0] dscp;
  } pkt_hdr_t;

  // classification states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SCAN = 2'b01,
    ST_DONE = 2'b11
  } scan_state_t;

endpackage

/* test/pkt_source.sv */
// far side model: ingress parser that offers headers and collects verdicts
`timescale 1ns/10ps
module pkt_source (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // bench side
  input wire logic go,
  input wire acl_filter_pkg::pkt_hdr_t hdr_in,
  output logic done,
  output logic permit,
  // filter side
  output logic pkt_valid,
  input wire logic pkt_ready,
  output acl_filter_pkg::pkt_hdr_t pkt_hdr,
  input wire logic verdict_valid,
  input wire logic verdict_permit
);
  logic busy;
  // hold the offer until taken; a released header is inverted so stale data never matches
  always_ff @(posedge mclk)
  begin
    done <= 1'b0;
    if (sys_rst)
    begin
      pkt_valid <= 1'b0;
      busy <= 1'b0;
      pkt_hdr <= '0;
    end
    else if (go && !pkt_valid && !busy)
    begin
      pkt_valid <= 1'b1;
      pkt_hdr <= hdr_in;
    end
    else if (pkt_valid && pkt_ready)
    begin
      pkt_valid <= 1'b0;
      pkt_hdr <= ~pkt_hdr;
      busy <= 1'b1;
    end
    else if (busy && verdict_valid)
    begin
      busy <= 1'b0;
      done <= 1'b1;
      permit <= verdict_permit;
    end
  end
endmodule // pkt_source

/* test/ipv4_access_list_filter_tb.sv */
// self-checking bench for the ipv4 access list filter
`timescale 1ns/10ps
module ipv4_access_list_filter_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic wr_en = 1'b0;
  logic [7:0] wr_index = 8'h00;
  acl_filter_pkg::acl_entry_t wr_entry = '0;
  logic del_entry = 1'b0;
  logic [7:0] del_index = 8'h00;
  logic del_list = 1'b0;
  logic [7:0] del_list_id = 8'h00;
  logic [7:0] rd_index = 8'h00;
  logic go = 1'b0;
  acl_filter_pkg::pkt_hdr_t hdr_in = '0;
  acl_filter_pkg::pkt_hdr_t pkt_hdr, h;
  acl_filter_pkg::acl_entry_t e;
  logic [47:0] rd_flag_text;
  logic rd_valid, pkt_valid, pkt_ready, verdict_valid, verdict_permit, done, permit;
  logic [7:0] pv [3] = '{8'h00, 8'h06, 8'hFF};
  logic [5:0] fv [4] = '{6'h22, 6'h2B, 6'h32, 6'h20};
  logic fx [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  int fail_count = 0;
  int cmp_count = 0;
  // 50 MHz clock
  always #10 mclk = ~mclk;
  ipv4_access_list_filter u_dut (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wr_en(wr_en),
    .wr_index(wr_index),
    .wr_entry(wr_entry),
    .del_entry(del_entry),
    .del_index(del_index),
    .del_list(del_list),
    .del_list_id(del_list_id),
    .rd_index(rd_index),
    .rd_flag_text(rd_flag_text),
    .rd_valid(rd_valid),
    .pkt_valid(pkt_valid),
    .pkt_ready(pkt_ready),
    .pkt_hdr(pkt_hdr),
    .verdict_valid(verdict_valid),
    .verdict_permit(verdict_permit)
  );
  pkt_source u_src (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .go(go),
    .hdr_in(hdr_in),
    .done(done),
    .permit(permit),
    .pkt_valid(pkt_valid),
    .pkt_ready(pkt_ready),
    .pkt_hdr(pkt_hdr),
    .verdict_valid(verdict_valid),
    .verdict_permit(verdict_permit)
  );
  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic acl_filter_pkg::acl_entry_t ent(input logic p);
    ent = '0;
    ent.valid = 1'b1;
    ent.list_id = 8'h01;
    ent.proto_any = 1'b1;
    ent.sport_any = 1'b1;
    ent.dport_any = 1'b1;
    ent.saddr_any = 1'b1;
    ent.daddr_any = 1'b1;
    ent.permit = p;
  endfunction
  function automatic acl_filter_pkg::pkt_hdr_t hb();
    hb = '0;
    hb.port_list = 8'h01;
    hb.bound = 1'b1;
    hb.proto = acl_filter_pkg::PROTO_TCP;
    hb.sport = 16'h0050;
    hb.dport = 16'h01BB;
    hb.flags = 6'h22;
    hb.saddr = 32'h0A000201;
    hb.daddr = 32'h0A00021C;
    hb.dscp = 6'h2E;
  endfunction
  task automatic wr(input logic [7:0] i, input acl_filter_pkg::acl_entry_t v);
    @(posedge mclk);
    wr_en <= 1'b1;
    wr_index <= i;
    wr_entry <= v;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  // one delete pulse: whole list when lst is set, else one slot
  task automatic del(input logic lst, input logic [7:0] i);
    @(posedge mclk);
    del_entry <= !lst;
    del_list <= lst;
    del_index <= i;
    del_list_id <= i;
    @(posedge mclk);
    del_entry <= 1'b0;
    del_list <= 1'b0;
  endtask
  task automatic snd(input acl_filter_pkg::pkt_hdr_t v, input logic exp);
    int n;
    n = 0;
    @(posedge mclk);
    go <= 1'b1;
    hdr_in <= v;
    @(posedge mclk);
    go <= 1'b0;
    while (done !== 1'b1 && n < 400)
    begin
      @(posedge mclk);
      n++;
    end
    chk("verdict_done", 1'b1, done);
    chk("verdict_permit", exp, permit);
  endtask
  task automatic rdk(input logic [7:0] i, input logic [47:0] exp, input logic vexp);
    @(posedge mclk);
    rd_index <= i;
    repeat (2) @(posedge mclk);
    chk("rd_flag_text", exp, rd_flag_text);
    chk("rd_valid", vexp, rd_valid);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios, in order
  initial
  begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    chk("pkt_ready", 1'b1, pkt_ready);
    chk("verdict_valid", 1'b0, verdict_valid);
    h = hb();
    h.bound = 1'b0;
    snd(h, 1'b1);
    snd(hb(), 1'b0);
    $display("test reset and default done");
    foreach (pv[k])
    begin
      e = ent(1'b1);
      e.proto_any = 1'b0;
      e.proto = pv[k];
      wr(8'h00, e);
      h.bound = 1'b1;
      h.proto = pv[k];
      snd(h, 1'b1);
      h.proto = pv[k] ^ 8'h01;
      snd(h, 1'b0);
    end
    $display("test protocol done");
    e = ent(1'b1);
    e.proto_any = 1'b0;
    e.proto = acl_filter_pkg::PROTO_TCP;
    e.sport_any = 1'b0;
    e.sport = 16'h0050;
    e.dport_any = 1'b0;
    e.dport = 16'h01BB;
    wr(8'h00, e);
    h = hb();
    snd(h, 1'b1);
    h.sport = 16'h0051;
    snd(h, 1'b0);
    h = hb();
    h.dport = 16'h01BC;
    snd(h, 1'b0);
    e.proto = acl_filter_pkg::PROTO_UDP;
    e.sport_any = 1'b1;
    e.dport_any = 1'b1;
    wr(8'h00, e);
    h.proto = acl_filter_pkg::PROTO_UDP;
    h.sport = 16'hFFFF;
    snd(h, 1'b1);
    e.proto = 8'h01;
    e.sport_any = 1'b0;
    e.dport_any = 1'b0;
    wr(8'h00, e);
    h.proto = 8'h01;
    snd(h, 1'b1);
    $display("test ports done");
    e = ent(1'b1);
    e.flags_en = 1'b1;
    e.flags = 12'h486;
    wr(8'h00, e);
    rdk(8'h00, 48'h313078303178, 1'b1);
    foreach (fv[k])
    begin
      h = hb();
      h.flags = fv[k];
      snd(h, fx[k]);
    end
    wr(8'h00, ent(1'b1));
    rdk(8'h00, 48'h787878787878, 1'b1);
    $display("test flags done");
    e = ent(1'b1);
    e.saddr_any = 1'b0;
    e.saddr = 32'h0A000200;
    e.smask = 32'hFFFFFF00;
    e.dmask = 32'hFFFFFFFF;
    wr(8'h00, e);
    h = hb();
    h.saddr = 32'h0A0002FF;
    h.daddr = 32'hC0A80001;
    snd(h, 1'b1);
    h.saddr = 32'h0A000300;
    snd(h, 1'b0);
    e.saddr_any = 1'b1;
    e.daddr_any = 1'b0;
    e.daddr = 32'h0A00021C;
    wr(8'h00, e);
    h.daddr = 32'h0A00021C;
    snd(h, 1'b1);
    h.daddr = 32'h0A00021D;
    snd(h, 1'b0);
    e.dmask = 32'h00000000;
    wr(8'h00, e);
    snd(h, 1'b1);
    $display("test address done");
    e = ent(1'b1);
    e.qos_sel = acl_filter_pkg::QOS_DSCP;
    e.qos_val = 6'h3F;
    wr(8'h00, e);
    h = hb();
    h.dscp = 6'h3F;
    snd(h, 1'b1);
    h.dscp = 6'h3E;
    snd(h, 1'b0);
    e.qos_sel = acl_filter_pkg::QOS_PREC;
    e.qos_val = 6'h05;
    wr(8'h00, e);
    h.dscp = 6'h2E;
    snd(h, 1'b1);
    h.dscp = 6'h36;
    snd(h, 1'b0);
    $display("test qos done");
    wr(8'h00, ent(1'b0));
    wr(8'h01, ent(1'b1));
    e = ent(1'b1);
    e.list_id = 8'h02;
    wr(8'h02, e);
    snd(hb(), 1'b0);
    del(1'b0, 8'h00);
    rdk(8'h00, 48'h787878787878, 1'b0);
    snd(hb(), 1'b1);
    rdk(8'h01, 48'h787878787878, 1'b1);
    del(1'b1, 8'h01);
    rdk(8'h01, 48'h787878787878, 1'b0);
    snd(hb(), 1'b0);
    h = hb();
    h.port_list = 8'h02;
    snd(h, 1'b1);
    $display("test order and delete done");
    // mid-run reset leaves every slot dead
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rdk(8'h02, 48'h787878787878, 1'b0);
    snd(h, 1'b0);
    $display("test mid-run reset done");
    conclude();
  end
  // watchdog: the scenarios need well under 10000 cycles
  initial
  begin
    repeat (30000) @(posedge mclk);
    fail_count++;
    conclude();
  end
endmodule // ipv4_access_list_filter_tb
